// ===== hdl/ppv_params.sv
// Profile position / profile velocity parameter, command and status block
//
// Function
// (R01) Absolute move target is the distance from the axis zero point.
// (R02) Relative base: 0 previous generator target, 2 actual position; 1 unsupported, max 2.
// (R03) Position speed is unsigned 32-bit rpm, min 1, default 60, clamped to limits.
// (R04) Persistent option: absolute moves only after homing; default off.
// (R05) Target position is signed 32-bit user units, default zero.
// (R06) Read-only actual and generator positions, signed 32-bit.
// (R07) Writing the velocity setpoint starts velocity mode.
// (R08) Velocity setpoint taken at once, even moving; no position range limits.
// (R09) Velocity setpoint signed 32-bit rpm, default zero, clamped to both limits.
// (R10) Velocity mode bit 10 set when reference speed reached or halted standstill.
// (R11) Velocity mode bits: 12 stopped, 13 error, 14 finished, 15 reference valid.
// (R12) Velocity mode ends at standstill on halt, error, or zero preset.
// (R13) Read-only actual speed signed 16-bit, generator speed signed 32-bit.
// (R14) Master selects absolute with control bit 6 clear, relative with it set.
// (R15) Positioning starts on rising edge of control bit 4.
// (R16) Bit 5 clear: sets written during a move are buffered, last wins.
// (R17) Absolute start refused with error when homing required and no reference.
// (R18) Out-of-limit speeds are saturated to the limit, not rejected.
`timescale 1ns/1ps
module ppv_params (
   input wire logic i_clk, // 250 MHz clock
   input wire logic i_rst, // Async reset, active high
   input wire ppv_pkg::ppv_bus_req_t i_bus, // Parameter access from fieldbus
   output logic [31:0] o_rdata, // Read data, registered
   output logic o_rvalid, // Read data valid, one cycle
   input wire logic [15:0] i_drive_control_word, // Control word from fieldbus
   input wire ppv_pkg::ppv_mode_t i_mode, // Selected operating mode
   input wire logic [31:0] i_ctrl_speed_limit, // Controller speed limit
   input wire logic [31:0] i_ramp_speed_limit, // Ramp speed limit
   input wire ppv_pkg::ppv_fb_t i_fb, // Drive feedback, same clock
   output ppv_pkg::ppv_move_t o_move, // Active positioning set
   output logic o_move_start, // Pulse: generator takes o_move
   output logic signed [31:0] o_vel_cmd, // Velocity command, rpm
   output logic o_vel_run, // Velocity mode active
   output logic [15:0] o_drive_status_word, // Status word
   output logic o_home_req_persist // Persistent option value for storage
);
   typedef struct packed {
      logic home_req;
      logic [1:0] rel_sel;
      logic signed [31:0] pp_target;
      logic [31:0] pp_speed;
      logic signed [31:0] pv_speed;
      logic cw4;
      logic moving;
      logic pend;
      logic rebuf;
      ppv_pkg::ppv_move_t pend_move;
      ppv_pkg::ppv_move_t move;
      logic start;
      logic vel_run;
      logic signed [31:0] vel_cmd;
      logic err;
      logic ack;
      logic done;
      logic [31:0] rdata;
      logic rvalid;
   } ppv_state_t;

   ppv_state_t s_q;
   ppv_state_t s_d;
   logic signed [31:0] pv_clamped;
   logic signed [31:0] pp_clamped;
   logic signed [31:0] abs_target;
   logic edge4;
   logic rel;

   assign rel = i_drive_control_word[ppv_pkg::CW_RELATIVE]; // [R14]
   assign edge4 = i_drive_control_word[ppv_pkg::CW_NEW_SETPOINT] && !s_q.cw4; // [R15]

   // Velocity setpoint saturation
   ppv_speed_clamp u_pv_clamp (
      .i_speed(s_q.pv_speed),
      .i_lim_a(i_ctrl_speed_limit),
      .i_lim_b(i_ramp_speed_limit),
      .o_speed(pv_clamped)
   );

   // Position speed saturation; unsigned value kept positive
   ppv_speed_clamp u_pp_clamp (
      .i_speed(s_q.pp_speed[31] ? 32'sh7FFFFFFF : $signed(s_q.pp_speed)),
      .i_lim_a(i_ctrl_speed_limit),
      .i_lim_b(i_ramp_speed_limit),
      .o_speed(pp_clamped)
   );

   // Absolute target from written value and chosen base
   ppv_target_calc u_target (
      .i_value(s_q.pp_target),
      .i_relative(rel),
      .i_rel_sel(s_q.rel_sel),
      .i_prev_target($signed(s_q.move.target)),
      .i_meas_pos($signed(i_fb.meas_pos)),
      .o_target(abs_target)
   );

   // Read mux: narrow registers in the low bits, speed sign-extended
   function automatic logic [31:0] read_reg(input logic [15:0] a, input ppv_state_t s, input ppv_pkg::ppv_fb_t f);
      case (a)
         ppv_pkg::ADDR_HOME_REQ: read_reg = {31'h0, s.home_req};
         ppv_pkg::ADDR_PV_SPEED: read_reg = s.pv_speed;
         ppv_pkg::ADDR_PP_TARGET: read_reg = s.pp_target;
         ppv_pkg::ADDR_PP_SPEED: read_reg = s.pp_speed;
         ppv_pkg::ADDR_REL_SEL: read_reg = {30'h0, s.rel_sel};
         ppv_pkg::ADDR_MEAS_SPEED: read_reg = {{16{f.meas_speed[15]}}, f.meas_speed}; // [R13]
         ppv_pkg::ADDR_MEAS_POS: read_reg = f.meas_pos; // [R06]
         ppv_pkg::ADDR_GEN_POS: read_reg = f.gen_pos; // [R06]
         ppv_pkg::ADDR_GEN_SPEED: read_reg = f.gen_speed; // [R13]
         default: read_reg = 32'h00000000;
      endcase
   endfunction

   // Next-state logic
   always_comb begin
      logic pos_write;
      ppv_pkg::ppv_move_t nm;
      s_d = s_q;
      pos_write = 1'b0;
      nm = '0;
      s_d.start = 1'b0;
      s_d.rvalid = i_bus.rd;
      if (i_bus.rd) begin
         s_d.rdata = read_reg(i_bus.addr, s_q, i_fb);
      end
      s_d.cw4 = i_drive_control_word[ppv_pkg::CW_NEW_SETPOINT];
      // Parameter writes; out-of-range values are ignored
      if (i_bus.wr) begin
         case (i_bus.addr)
            ppv_pkg::ADDR_HOME_REQ: begin
               if (i_bus.wdata <= 32'h00000001) begin
                  s_d.home_req = i_bus.wdata[0]; // [R04]
               end
            end
            ppv_pkg::ADDR_REL_SEL: begin
               if (i_bus.wdata <= {30'h0, ppv_pkg::REL_SEL_MAX} && i_bus.wdata != 32'h00000001) begin
                  s_d.rel_sel = i_bus.wdata[1:0]; // [R02]
               end
            end
            ppv_pkg::ADDR_PP_TARGET: begin
               s_d.pp_target = i_bus.wdata; // [R05]
               pos_write = 1'b1;
            end
            ppv_pkg::ADDR_PP_SPEED: begin
               if (i_bus.wdata >= ppv_pkg::PP_SPEED_MIN) begin
                  s_d.pp_speed = i_bus.wdata; // [R03]
                  pos_write = 1'b1;
               end
            end
            ppv_pkg::ADDR_PV_SPEED: begin
               s_d.pv_speed = i_bus.wdata; // [R09]
               if (i_mode == ppv_pkg::PPV_MODE_VELOCITY) begin
                  s_d.vel_run = 1'b1; // [R07]
                  s_d.done = 1'b0;
                  s_d.err = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Buffered set is rebuilt a cycle after a write, once the new value is registered
      s_d.rebuf = pos_write;
      // Velocity mode: clamped setpoint follows at once, no range limits
      if (i_mode == ppv_pkg::PPV_MODE_VELOCITY) begin
         s_d.vel_cmd = s_q.vel_run ? pv_clamped : 32'sh0; // [R08] [R18]
         if (s_q.vel_run && i_fb.standstill && (i_fb.halt || i_fb.fault || s_q.pv_speed == 32'sh0)) begin
            s_d.vel_run = 1'b0; // [R12]
            s_d.done = 1'b1;
            s_d.err = i_fb.fault;
         end
      end else begin
         s_d.vel_run = 1'b0;
         s_d.vel_cmd = 32'sh0;
      end
      // Position mode: set built from current parameters
      nm.target = abs_target; // [R01]
      nm.speed = pp_clamped; // [R03] [R18]
      nm.relative = rel;
      nm.rel_sel = s_q.rel_sel;
      if (i_mode == ppv_pkg::PPV_MODE_POSITION) begin
         if (edge4) begin
            if (!rel && s_q.home_req && !i_fb.ref_ok) begin
               s_d.err = 1'b1; // [R17]
            end else if (s_q.moving && !i_drive_control_word[ppv_pkg::CW_CHANGE_NOW]) begin
               s_d.pend = 1'b1; // [R16]
               s_d.pend_move = nm;
               s_d.ack = 1'b1;
            end else begin
               s_d.move = nm; // [R15]
               s_d.start = 1'b1;
               s_d.moving = 1'b1;
               s_d.done = 1'b0;
               s_d.err = 1'b0;
               s_d.ack = 1'b1;
            end
         end else if (s_q.rebuf && s_q.pend) begin
            s_d.pend_move = nm; // Last write overwrites buffered set [R16]
         end
         if (!i_drive_control_word[ppv_pkg::CW_NEW_SETPOINT] && !edge4) begin
            s_d.ack = 1'b0;
         end
         // At standstill: run buffered set if target reached, else finish
         if (s_q.moving && i_fb.standstill && !s_q.start) begin
            if (i_fb.target_reached && s_q.pend) begin
               s_d.move = s_q.pend_move; // [R16]
               s_d.pend = 1'b0;
               s_d.start = 1'b1;
            end else begin
               s_d.moving = 1'b0;
               s_d.pend = 1'b0;
               s_d.done = 1'b1;
               s_d.err = s_q.err | i_fb.fault;
            end
         end
      end else begin
         s_d.moving = 1'b0;
         s_d.pend = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.pp_speed <= ppv_pkg::RST_PP_SPEED;
         s_q.pv_speed <= ppv_pkg::RST_PV_SPEED;
         s_q.pp_target <= ppv_pkg::RST_PP_TARGET;
         s_q.rel_sel <= ppv_pkg::RST_REL_SEL;
         s_q.home_req <= ppv_pkg::RST_HOME_REQ;
      end else begin
         s_q <= s_d;
      end
   end

   // Status word: bits depend on mode
   always_comb begin
      o_drive_status_word = 16'h0000;
      o_drive_status_word[ppv_pkg::SW_REF_OK] = i_fb.ref_ok; // [R11]
      o_drive_status_word[ppv_pkg::SW_ERROR] = s_q.err | i_fb.fault; // [R11] [R17]
      o_drive_status_word[ppv_pkg::SW_MODE_END] = s_q.done; // [R11]
      if (i_mode == ppv_pkg::PPV_MODE_VELOCITY) begin
         o_drive_status_word[ppv_pkg::SW_TARGET_REACHED] = i_fb.target_reached || (i_fb.halt && i_fb.standstill); // [R10]
         o_drive_status_word[ppv_pkg::SW_ACK_OR_STOP] = i_fb.standstill; // [R11]
      end else if (i_mode == ppv_pkg::PPV_MODE_POSITION) begin
         o_drive_status_word[ppv_pkg::SW_TARGET_REACHED] = s_q.done && i_fb.target_reached && !i_fb.halt;
         o_drive_status_word[ppv_pkg::SW_ACK_OR_STOP] = s_q.ack;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_rvalid = s_q.rvalid;
   assign o_move = s_q.move;
   assign o_move_start = s_q.start;
   assign o_vel_cmd = s_q.vel_cmd;
   assign o_vel_run = s_q.vel_run;
   assign o_home_req_persist = s_q.home_req;
endmodule // ppv_params

// ===== hdl/ppv_pkg.sv
// Package: register map, field layout, reset values and types of the position/velocity parameter block
package ppv_pkg;
   // Register addresses (fieldbus parameter addresses)
   localparam logic [15:0] ADDR_HOME_REQ = 16'h062C;
   localparam logic [15:0] ADDR_PV_SPEED = 16'h1B1A;
   localparam logic [15:0] ADDR_PP_TARGET = 16'h1B1C;
   localparam logic [15:0] ADDR_PP_SPEED = 16'h1B1E;
   localparam logic [15:0] ADDR_REL_SEL = 16'h1B30;
   localparam logic [15:0] ADDR_MEAS_SPEED = 16'h1E10;
   localparam logic [15:0] ADDR_MEAS_POS = 16'h1E1A;
   localparam logic [15:0] ADDR_GEN_POS = 16'h1F04;
   localparam logic [15:0] ADDR_GEN_SPEED = 16'h1F0C;
   // Reset values
   localparam logic [31:0] RST_PP_SPEED = 32'h0000003C;
   localparam logic [31:0] RST_PV_SPEED = 32'h00000000;
   localparam logic [31:0] RST_PP_TARGET = 32'h00000000;
   localparam logic [1:0] RST_REL_SEL = 2'h0;
   localparam logic RST_HOME_REQ = 1'b0;
   // Limits
   localparam logic [31:0] PP_SPEED_MIN = 32'h00000001;
   localparam logic [1:0] REL_SEL_MAX = 2'h2;
   localparam logic [1:0] REL_SEL_PREV = 2'h0;
   localparam logic [1:0] REL_SEL_ACT = 2'h2;
   // Control word bits
   localparam int CW_NEW_SETPOINT = 4;
   localparam int CW_CHANGE_NOW = 5;
   localparam int CW_RELATIVE = 6;
   // Status word bits
   localparam int SW_TARGET_REACHED = 10;
   localparam int SW_ACK_OR_STOP = 12;
   localparam int SW_ERROR = 13;
   localparam int SW_MODE_END = 14;
   localparam int SW_REF_OK = 15;

   typedef enum logic [1:0] {
      PPV_MODE_NONE,
      PPV_MODE_POSITION,
      PPV_MODE_VELOCITY
   } ppv_mode_t;

   // One register access from the fieldbus side
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } ppv_bus_req_t;

   // One positioning set, as handed to the profile generator
   typedef struct packed {
      logic [31:0] target;
      logic [31:0] speed;
      logic relative;
      logic [1:0] rel_sel;
   } ppv_move_t;

   // Drive-side feedback
   typedef struct packed {
      logic [15:0] meas_speed;
      logic [31:0] meas_pos;
      logic [31:0] gen_pos;
      logic [31:0] gen_speed;
      logic target_reached;
      logic standstill;
      logic halt;
      logic fault;
      logic ref_ok;
   } ppv_fb_t;
endpackage

// ===== hdl/ppv_speed_clamp.sv
// Speed clamp: saturates a signed speed to the lower of two unsigned limits
`timescale 1ns/1ps
module ppv_speed_clamp (
   input wire logic signed [31:0] i_speed, // Requested speed, rpm
   input wire logic [31:0] i_lim_a, // Controller speed limit
   input wire logic [31:0] i_lim_b, // Ramp speed limit
   output logic signed [31:0] o_speed // Saturated speed
);
   logic [31:0] lim;
   // Tighter of the two limits; kept below 2^31 so negation stays representable
   always_comb begin
      lim = (i_lim_a < i_lim_b) ? i_lim_a : i_lim_b;
      if (lim[31]) begin
         lim = 32'h7FFFFFFF;
      end
      if (i_speed > $signed(lim)) begin
         o_speed = $signed(lim); // Saturate rather than reject
      end else if (i_speed < -$signed(lim)) begin
         o_speed = -$signed(lim);
      end else begin
         o_speed = i_speed;
      end
   end
endmodule // ppv_speed_clamp

// ===== hdl/ppv_target_calc.sv
// Absolute target calculation for absolute and relative moves
`timescale 1ns/1ps
module ppv_target_calc (
   input wire logic signed [31:0] i_value, // Written target position, usr
   input wire logic i_relative, // Relative move requested
   input wire logic [1:0] i_rel_sel, // Base selection for relative moves
   input wire logic signed [31:0] i_prev_target, // Previous generator target
   input wire logic signed [31:0] i_meas_pos, // Actual motor position
   output logic signed [31:0] o_target // Resulting absolute target
);
   // Absolute: value is distance from axis zero; relative: added to selected base
   always_comb begin
      if (!i_relative) begin
         o_target = i_value;
      end else if (i_rel_sel == ppv_pkg::REL_SEL_ACT) begin
         o_target = i_value + i_meas_pos;
      end else begin
         o_target = i_value + i_prev_target;
      end
   end
endmodule // ppv_target_calc

// ===== verif/ppv_params_checker.sv
// Checker: timing and value relations at the ports of the parameter block
`timescale 1ns/1ps
module ppv_params_checker (
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Async reset
   input wire ppv_pkg::ppv_bus_req_t i_bus, // Parameter access
   input wire logic [31:0] o_rdata, // Read data
   input wire logic o_rvalid, // Read valid
   input wire logic [15:0] i_drive_control_word, // Control word
   input wire ppv_pkg::ppv_mode_t i_mode, // Mode
   input wire logic [31:0] i_ctrl_speed_limit, // Controller limit
   input wire logic [31:0] i_ramp_speed_limit, // Ramp limit
   input wire ppv_pkg::ppv_fb_t i_fb, // Feedback
   input wire ppv_pkg::ppv_move_t o_move, // Move set
   input wire logic o_move_start, // Start pulse
   input wire logic signed [31:0] o_vel_cmd, // Velocity command
   input wire logic o_vel_run, // Velocity active
   input wire logic [15:0] o_drive_status_word, // Status word
   input wire logic o_home_req_persist // Homing option
);
   logic [31:0] vel_mag;
   // Magnitude, since both directions share one limit
   assign vel_mag = o_vel_cmd[31] ? 32'(-o_vel_cmd) : 32'(o_vel_cmd);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Absolute start request: rising new-setpoint bit in position mode
   sequence s_abs_edge;
      i_mode == ppv_pkg::PPV_MODE_POSITION && i_drive_control_word[4] && !$past(i_drive_control_word[4])
      && !i_drive_control_word[6];
   endsequence
   sequence s_abs_blocked;
      s_abs_edge ##0 (o_home_req_persist && !i_fb.ref_ok);
   endsequence
   sequence s_vel_wr;
      i_bus.wr && i_bus.addr == ppv_pkg::ADDR_PV_SPEED && i_mode == ppv_pkg::PPV_MODE_VELOCITY && i_bus.wdata != 0;
   endsequence
   a_read_answer: assert property (i_bus.rd |=> o_rvalid)
      else $error("read not answered next cycle");
   a_rvalid_cause: assert property (o_rvalid |-> $past(i_bus.rd))
      else $error("read valid without request");
   a_abs_refused: assert property (s_abs_blocked |=> !o_move_start && o_drive_status_word[13])
      else $error("absolute start not refused");
   a_vel_start: assert property (s_vel_wr |=> o_vel_run)
      else $error("velocity mode not started by setpoint write");
   a_vel_clamp: assert property (o_vel_run |-> vel_mag <= i_ctrl_speed_limit && vel_mag <= i_ramp_speed_limit)
      else $error("velocity command above limit");
   a_move_speed: assert property (o_move_start |-> o_move.speed >= 1 && o_move.speed <= i_ramp_speed_limit
      && o_move.speed <= i_ctrl_speed_limit)
      else $error("move speed outside range");
   a_vel_stopped: assert property (i_mode == ppv_pkg::PPV_MODE_VELOCITY |-> o_drive_status_word[12] == i_fb.standstill)
      else $error("stopped bit wrong");
   a_ref_ok_bit: assert property (o_drive_status_word[15] == i_fb.ref_ok)
      else $error("reference bit wrong");
endmodule // ppv_params_checker
bind ppv_params ppv_params_checker ppv_params_checker_i (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_drive_control_word(i_drive_control_word), .i_mode(i_mode),
   .i_ctrl_speed_limit(i_ctrl_speed_limit), .i_ramp_speed_limit(i_ramp_speed_limit), .i_fb(i_fb),
   .o_move(o_move), .o_move_start(o_move_start), .o_vel_cmd(o_vel_cmd), .o_vel_run(o_vel_run),
   .o_drive_status_word(o_drive_status_word), .o_home_req_persist(o_home_req_persist));

// ===== verif/ppv_master.sv
// Fieldbus master model: parameter write and read cycles
`timescale 1ns/1ps
module ppv_master (
   input wire logic i_clk, // Bench clock
   input wire logic [31:0] i_rdata, // Read data from block
   input wire logic i_rvalid, // Read data valid
   output ppv_pkg::ppv_bus_req_t o_bus // Request to block
);
   initial o_bus = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 32'h00000000};
   // Released lines show inverted values so stale data never looks valid
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk) #1;
      o_bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk) #1;
      o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // Answer is taken in the cycle after the request edge
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
      @(posedge i_clk) #1;
      o_bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
      @(posedge i_clk) #1;
      o_bus.rd = 1'b0;
      o_bus.addr = ~a;
      d = i_rdata;
      v = i_rvalid;
   endtask
endmodule // ppv_master

// ===== verif/ppv_params_tb.sv
// Testbench: registers, positioning start and velocity mode of the parameter block
`timescale 1ns/1ps
module ppv_params_tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   ppv_pkg::ppv_bus_req_t bus;
   logic [31:0] rdata;
   logic rvalid;
   logic [15:0] cw = 16'h0000;
   ppv_pkg::ppv_mode_t mode = ppv_pkg::PPV_MODE_NONE;
   ppv_pkg::ppv_fb_t fb = '0;
   ppv_pkg::ppv_move_t move;
   logic move_start, vel_run, home_persist, got;
   logic signed [31:0] vel_cmd;
   logic [15:0] sw;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   // Limits fixed: ramp limit 2000 is the tighter one
   ppv_params ppv_params_i (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_drive_control_word(cw), .i_mode(mode), .i_ctrl_speed_limit(32'h00000BB8),
      .i_ramp_speed_limit(32'h000007D0), .i_fb(fb), .o_move(move), .o_move_start(move_start),
      .o_vel_cmd(vel_cmd), .o_vel_run(vel_run), .o_drive_status_word(sw), .o_home_req_persist(home_persist));
   ppv_master ppv_master_i (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));
   always #2 i_clk = ~i_clk;
   // Hang guard, far above the roughly 112 cycles the tests need
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("tests %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic v;
      ppv_master_i.rd(a, d, v);
      check({n, " valid"}, {31'h0, v}, 32'h00000001);
      check(n, d, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // New-setpoint edge with the given relative bit, start looked for over four cycles
   task automatic pos_start(input logic rel);
      cw = {9'h000, rel, 6'h00};
      tick(1);
      cw[4] = 1'b1;
      got = 1'b0;
      repeat (4) begin
         tick(1);
         if (move_start === 1'b1) got = 1'b1;
      end
      cw[4] = 1'b0;
   endtask
   initial begin
      fb.meas_speed = 16'hFF38;
      fb.meas_pos = 32'h00001000;
      fb.gen_pos = 32'hFFFFF000;
      fb.gen_speed = 32'h00000123;
      fb.standstill = 1'b1;
      fb.target_reached = 1'b1;
      repeat (4) @(posedge i_clk);
      #1 i_rst = 1'b0;
      rchk("home_req", ppv_pkg::ADDR_HOME_REQ, 32'h00000000);
      rchk("vel_setpoint", ppv_pkg::ADDR_PV_SPEED, 32'h00000000);
      rchk("target", ppv_pkg::ADDR_PP_TARGET, 32'h00000000);
      rchk("pos_speed", ppv_pkg::ADDR_PP_SPEED, 32'h0000003C);
      rchk("rel_sel", ppv_pkg::ADDR_REL_SEL, 32'h00000000);
      rchk("meas_speed", ppv_pkg::ADDR_MEAS_SPEED, 32'hFFFFFF38);
      rchk("gen_speed", ppv_pkg::ADDR_GEN_SPEED, 32'h00000123);
      rchk("meas_pos", ppv_pkg::ADDR_MEAS_POS, 32'h00001000);
      rchk("gen_pos", ppv_pkg::ADDR_GEN_POS, 32'hFFFFF000);
      rchk("unmapped", 16'h0000, 32'h00000000);
      $display("test reset_values done");
      ppv_master_i.wr(ppv_pkg::ADDR_REL_SEL, 32'h00000001);
      rchk("rel_sel one", ppv_pkg::ADDR_REL_SEL, 32'h00000000);
      ppv_master_i.wr(ppv_pkg::ADDR_REL_SEL, 32'h00000002);
      ppv_master_i.wr(ppv_pkg::ADDR_REL_SEL, 32'h00000003);
      rchk("rel_sel max", ppv_pkg::ADDR_REL_SEL, 32'h00000002);
      ppv_master_i.wr(ppv_pkg::ADDR_PP_SPEED, 32'h00000000);
      rchk("pos_speed zero", ppv_pkg::ADDR_PP_SPEED, 32'h0000003C);
      ppv_master_i.wr(ppv_pkg::ADDR_HOME_REQ, 32'h00000002);
      rchk("home_req two", ppv_pkg::ADDR_HOME_REQ, 32'h00000000);
      ppv_master_i.wr(ppv_pkg::ADDR_HOME_REQ, 32'h00000001);
      rchk("home_req one", ppv_pkg::ADDR_HOME_REQ, 32'h00000001);
      check("home persist", {31'h0, home_persist}, 32'h00000001);
      ppv_master_i.wr(ppv_pkg::ADDR_PP_TARGET, 32'hFFFFFFFB);
      rchk("target neg", ppv_pkg::ADDR_PP_TARGET, 32'hFFFFFFFB);
      ppv_master_i.wr(ppv_pkg::ADDR_MEAS_POS, 32'h00000005);
      rchk("meas_pos ro", ppv_pkg::ADDR_MEAS_POS, 32'h00001000);
      $display("test register_writes done");
      // Homing required, no reference: absolute refused, relative allowed
      mode = ppv_pkg::PPV_MODE_POSITION;
      pos_start(1'b0);
      check("abs refused", {31'h0, got}, 32'h00000000);
      check("error bit", {31'h0, sw[13]}, 32'h00000001);
      pos_start(1'b1);
      check("rel start", {31'h0, got}, 32'h00000001);
      check("rel target", move.target, 32'h00000FFB);
      fb.ref_ok = 1'b1;
      ppv_master_i.wr(ppv_pkg::ADDR_PP_SPEED, 32'h00001388);
      ppv_master_i.wr(ppv_pkg::ADDR_PP_TARGET, 32'h00000200);
      pos_start(1'b0);
      check("abs start", {31'h0, got}, 32'h00000001);
      check("abs target", move.target, 32'h00000200);
      check("move speed", move.speed, 32'h000007D0);
      check("error cleared", {31'h0, sw[13]}, 32'h00000000);
      $display("test positioning done");
      mode = ppv_pkg::PPV_MODE_VELOCITY;
      fb.standstill = 1'b0;
      fb.target_reached = 1'b0;
      ppv_master_i.wr(ppv_pkg::ADDR_PV_SPEED, 32'h00000064);
      tick(2);
      check("vel run", {31'h0, vel_run}, 32'h00000001);
      check("vel cmd", vel_cmd, 32'h00000064);
      check("moving bit", {31'h0, sw[12]}, 32'h00000000);
      ppv_master_i.wr(ppv_pkg::ADDR_PV_SPEED, 32'hFFFFD8F1);
      tick(2);
      check("vel clamp", vel_cmd, 32'hFFFFF830);
      fb.halt = 1'b1;
      fb.standstill = 1'b1;
      tick(3);
      check("halt ends", {31'h0, vel_run}, 32'h00000000);
      check("end bit", {31'h0, sw[14]}, 32'h00000001);
      check("reached bit", {31'h0, sw[10]}, 32'h00000001);
      check("stopped bit", {31'h0, sw[12]}, 32'h00000001);
      fb.halt = 1'b0;
      fb.standstill = 1'b0;
      ppv_master_i.wr(ppv_pkg::ADDR_PV_SPEED, 32'h00000064);
      ppv_master_i.wr(ppv_pkg::ADDR_PV_SPEED, 32'h00000000);
      fb.standstill = 1'b1;
      tick(3);
      check("zero ends", {31'h0, vel_run}, 32'h00000000);
      $display("test velocity done");
      // Moving with bit 5 clear: second set buffered, last written target wins
      mode = ppv_pkg::PPV_MODE_POSITION;
      fb.standstill = 1'b0;
      fb.target_reached = 1'b0;
      ppv_master_i.wr(ppv_pkg::ADDR_PP_TARGET, 32'h00000300);
      pos_start(1'b0);
      check("first start", {31'h0, got}, 32'h00000001);
      ppv_master_i.wr(ppv_pkg::ADDR_PP_TARGET, 32'h00000500);
      pos_start(1'b0);
      check("buffered", {31'h0, got}, 32'h00000000);
      check("buf target", move.target, 32'h00000300);
      ppv_master_i.wr(ppv_pkg::ADDR_PP_TARGET, 32'h00000600);
      tick(2);
      fb.standstill = 1'b1;
      fb.target_reached = 1'b1;
      tick(3);
      check("last wins", move.target, 32'h00000600);
      $display("test buffering done");
      report_and_stop();
   end
endmodule // ppv_params_tb
